/* File: verilog/wdpm_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes pclk at 10 MHz and a 32-bit apb slave with byte addresses
`ifndef WDPM_REGS_SVH
`define WDPM_REGS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define OFF_CTRL       8'h00
`define OFF_REFRESH    8'h04
`define OFF_POWER      8'h08
`define OFF_STATUS     8'h0C
`define OFF_IRQ_STAT   8'h10
`define OFF_IRQ_MASK   8'h14
`define OFF_COUNT      8'h18

// ************************************************************
// field positions
// ************************************************************
`define CTRL_START     0
`define PWR_IDLE_ARM   0
`define PWR_PD_ARM     1
`define PWR_SLOW       4
`define PWR_IDLE_SET   5
`define PWR_PD_SET     6
`define IRQ_WDT        0
`define IRQ_IDLE_EXIT  1
`define IRQ_PD_EXIT    2

// ************************************************************
// reset values
// ************************************************************
`define IRQ_RESET      3'h0
`define CNT_RESET      16'h0000

// ************************************************************
// timing
// ************************************************************
`define CLK_PERIOD_NS  100
`define WDT_TICK_NS    1000
`define WDT_TICK_CYC   ((`WDT_TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDT_LIMIT      16'hFFFC
`define WDT_RST_NS     4000
`define WDT_RST_CYC    ((`WDT_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_DIV       8

`endif

/* File: verilog/wdpm_pkg.sv */
// types shared by the watchdog and power mode logic
// assumes nothing beyond a single clock domain
package wdpm_pkg;

   typedef enum logic [1:0] {
      PM_ACTIVE = 2'b00,
      PM_IDLE   = 2'b01,
      PM_PDOWN  = 2'b10
   } pm_type;

   typedef enum logic [1:0] {
      WD_OFF = 2'b00,
      WD_RUN = 2'b01,
      WD_RST = 2'b10
   } wd_type;

endpackage

/* File: verilog/clk_ctrl_if.sv */
// bundle between the mode controller and the clock enable generator
// assumes both ends sit on pclk
`timescale 1ns/10ps
interface clk_ctrl_if;
   logic idle;
   logic pd;
   logic slow;
   logic cpu_en;
   logic per_en;

   modport ctl (output idle, output pd, output slow, input cpu_en, input per_en);
   modport gen (input idle, input pd, input slow, output cpu_en, output per_en);
endinterface

/* File: verilog/pin_sync.sv */
// three-stage synchroniser for an asynchronous pin
// assumes the pin idles high
`timescale 1ns/10ps
module pin_sync (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin,
   output var  logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= 1'b1;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end

   assign level = level_q;
endmodule // pin_sync

/* File: verilog/clk_divider.sv */
// clock enable generator for cpu and peripherals
// assumes pclk is the oscillator; enables stand in for gated clocks
`timescale 1ns/10ps
module clk_divider #(
   parameter int unsigned DIV = 8
) (
   input  wire logic pclk,
   input  wire logic presetn,
   clk_ctrl_if.gen   ck
);
   localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

   logic [W-1:0] div_q;
   logic         tick;

   if (DIV < 2 || (DIV & (DIV - 1)) != 0) begin : bad_div
      $error("clk_divider: DIV must be a power of two of at least 2");
   end

   // free running so the slow phase never drifts between modes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + W'(1);
      end
   end

   assign tick      = (div_q == W'(DIV - 1));
   assign ck.per_en = !ck.pd && (!ck.slow || tick);                // [R10] [R11]
   assign ck.cpu_en = !ck.pd && !ck.idle && (!ck.slow || tick);    // [R6] [R10]
endmodule // clk_divider

/* File: verilog/wdpm_top.sv */
// watchdog and power mode controller with apb register access
// assumes a same-clock peripheral interrupt and an async ext interrupt 0 pin
//
// Contract
// R1 - refresh within limit, else internal reset
// R2 - only software starts watchdog; never stopped
// R3 - at FFFC reset, lasting four instruction cycles
// R4 - watchdog reset keeps watchdog running
// R5 - flag records a watchdog caused reset
// R6 - idle gates cpu, peripherals keep clock
// R7 - idle by 01 then 20; leave on irq
// R8 - power down by 02 then 40; pin exit
// R9 - power down retains all register contents
// R10 - slow bit divides all clocks by eight
// R11 - slow with idle: cpu stopped, peripherals slowed
// R12 - second write must follow first directly
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "wdpm_regs.svh"
module wdpm_top #(
   parameter int unsigned TICK_CYC  = `WDT_TICK_CYC,
   parameter logic [15:0] WDT_LIMIT = `WDT_LIMIT,
   parameter int unsigned RST_CYC   = `WDT_RST_CYC,
   parameter int unsigned SLOW_DIV  = `SLOW_DIV
) (
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [7:0]     paddr,
   input  wire logic [31:0]    pwdata,
   output var  logic [31:0]    prdata,
   output var  logic           pready,
   output var  logic           pslverr,
   input  wire logic           periph_irq,
   input  wire logic           ext_interrupt0_pin,
   output var  logic           irq,
   output var  logic           wdt_reset_out,
   output var  logic           cpu_clk_en,
   output var  logic           periph_clk_en,
   output var  logic           osc_en,
   output var  wdpm_pkg::pm_type power_mode
);
   import wdpm_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   wd_type       wd_q;
   pm_type       pm_q;
   logic [15:0]  cnt_q;
   logic [15:0]  pre_q;
   logic [15:0]  rst_cnt_q;
   logic         flag_q;
   logic         idle_arm_q;
   logic         pd_arm_q;
   logic         slow_q;
   logic [2:0]   stat_q;
   logic [2:0]   mask_q;
   logic         irq_q;
   logic [31:0]  prdata_q;
   logic [31:0]  rdata_d;
   logic [2:0]   ev;
   logic         apb_wr;
   logic         wr;
   logic         wr_ctrl;
   logic         wr_refresh;
   logic         wr_power_control_register;
   logic         wr_stat;
   logic         wr_mask;
   logic         tick;
   logic         fire;
   logic         int_rst;
   logic         enter_idle;
   logic         enter_pd;
   logic         pin_level;
   logic         pin_low;

   clk_ctrl_if ck ();

   if (TICK_CYC < 1 || TICK_CYC > 65536 || RST_CYC < 1 || RST_CYC > 65536 || WDT_LIMIT == 16'h0000)
   begin : bad_param
      $error("wdpm_top: timing parameters out of range");
   end

   // ************************************************************
   // apb slave
   // ************************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, `OFF_CTRL) || hit(a, `OFF_REFRESH) || hit(a, `OFF_POWER) ||
               hit(a, `OFF_STATUS) || hit(a, `OFF_IRQ_STAT) || hit(a, `OFF_IRQ_MASK) ||
               hit(a, `OFF_COUNT);
   endfunction

   // zero wait states; read data is caught in the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign apb_wr  = psel && penable && pwrite && mapped(paddr);
   // cpu is halted in power down, so no register may be written there
   assign wr      = apb_wr && (pm_q != PM_PDOWN);                     // [R9]

   always_comb begin
      wr_ctrl    = 1'b0;
      wr_refresh = 1'b0;
      wr_power_control_register    = 1'b0;
      wr_stat    = 1'b0;
      wr_mask    = 1'b0;
      if (!wr) begin
         wr_ctrl = 1'b0;
      end else if (hit(paddr, `OFF_CTRL)) begin
         wr_ctrl = 1'b1;
      end else if (hit(paddr, `OFF_REFRESH)) begin
         wr_refresh = 1'b1;
      end else if (hit(paddr, `OFF_POWER)) begin
         wr_power_control_register = 1'b1;
      end else if (hit(paddr, `OFF_IRQ_STAT)) begin
         wr_stat = 1'b1;
      end else if (hit(paddr, `OFF_IRQ_MASK)) begin
         wr_mask = 1'b1;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit(paddr, `OFF_CTRL)) begin
         rdata_d[`CTRL_START] = (wd_q != WD_OFF);
      end else if (hit(paddr, `OFF_POWER)) begin
         rdata_d[`PWR_IDLE_ARM] = idle_arm_q;
         rdata_d[`PWR_PD_ARM]   = pd_arm_q;
         rdata_d[`PWR_SLOW]     = slow_q;
         rdata_d[`PWR_IDLE_SET] = (pm_q == PM_IDLE);
         rdata_d[`PWR_PD_SET]   = (pm_q == PM_PDOWN);
      end else if (hit(paddr, `OFF_STATUS)) begin
         rdata_d[0]   = flag_q;                                      // [R5]
         rdata_d[1]   = (wd_q != WD_OFF);
         rdata_d[2]   = (wd_q == WD_RST);
         rdata_d[3]   = slow_q;
         rdata_d[5:4] = pm_q;
      end else if (hit(paddr, `OFF_IRQ_STAT)) begin
         rdata_d = 32'(stat_q);
      end else if (hit(paddr, `OFF_IRQ_MASK)) begin
         rdata_d = 32'(mask_q);
      end else if (hit(paddr, `OFF_COUNT)) begin
         rdata_d = 32'(cnt_q);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_q <= rdata_d;
      end
   end

   assign prdata = prdata_q;

   // ************************************************************
   // watchdog
   // ************************************************************
   // prescaler follows the peripheral enable, so slow down and power down slow or freeze it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 16'h0000;
      end else if (wd_q != WD_RUN || wr_refresh) begin
         pre_q <= 16'h0000;
      end else if (ck.per_en) begin
         pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
      end
   end

   assign tick = ck.per_en && (pre_q == 16'(TICK_CYC - 1));
   // a refresh in the overflow cycle still saves the device
   assign fire = (wd_q == WD_RUN) && (cnt_q == WDT_LIMIT) && !wr_refresh;   // [R1] [R3]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= `CNT_RESET;
      end else if (wr_refresh || fire || wd_q == WD_RST) begin
         cnt_q <= `CNT_RESET;                                         // [R1] [R4]
      end else if (wd_q != WD_OFF && tick && cnt_q != WDT_LIMIT) begin
         cnt_q <= cnt_q + 16'h0001;                                   // [R4]
      end
   end

   // only presetn returns the watchdog to off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_q <= WD_OFF;
      end else begin
         case (wd_q)
            WD_OFF: begin
               if (wr_ctrl && pwdata[`CTRL_START]) begin
                  wd_q <= WD_RUN;                                     // [R2]
               end
            end
            WD_RUN: begin
               if (fire) begin
                  wd_q <= WD_RST;                                     // [R3]
               end
            end
            WD_RST: begin
               if (rst_cnt_q == 16'(RST_CYC - 1)) begin
                  wd_q <= WD_RUN;                                     // [R4]
               end
            end
            default: begin
               wd_q <= WD_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_cnt_q <= 16'h0000;
      end else if (wd_q == WD_RST) begin
         rst_cnt_q <= rst_cnt_q + 16'h0001;                           // [R3]
      end else begin
         rst_cnt_q <= 16'h0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end else if (fire) begin
         flag_q <= 1'b1;                                              // [R5]
      end
   end

   assign int_rst       = (wd_q == WD_RST);
   assign wdt_reset_out = int_rst;

   // ************************************************************
   // power modes
   // ************************************************************
   pin_sync u_pin_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (ext_interrupt0_pin),
      .level   (pin_level)
   );

   assign pin_low    = !pin_level;
   assign enter_pd   = wr_power_control_register && (pm_q == PM_ACTIVE) && pd_arm_q && pwdata[`PWR_PD_SET];      // [R8] [R12]
   assign enter_idle = wr_power_control_register && (pm_q == PM_ACTIVE) && idle_arm_q && pwdata[`PWR_IDLE_SET]
                       && !enter_pd;                                                         // [R7] [R12]

   // arming survives only until the next write to any mapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_arm_q <= 1'b0;
         pd_arm_q   <= 1'b0;
      end else if (int_rst) begin
         idle_arm_q <= 1'b0;
         pd_arm_q   <= 1'b0;
      end else if (wr) begin
         idle_arm_q <= wr_power_control_register && pwdata[`PWR_IDLE_ARM] && !enter_idle && !enter_pd;        // [R12]
         pd_arm_q   <= wr_power_control_register && pwdata[`PWR_PD_ARM] && !enter_idle && !enter_pd;          // [R12]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_q <= 1'b0;
      end else if (int_rst) begin
         slow_q <= 1'b0;                                              // [R10]
      end else if (wr_power_control_register) begin
         slow_q <= pwdata[`PWR_SLOW];                                 // [R10] [R11]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pm_q <= PM_ACTIVE;
      end else if (int_rst) begin
         pm_q <= PM_ACTIVE;                                           // [R4]
      end else begin
         case (pm_q)
            PM_ACTIVE: begin
               if (enter_pd) begin
                  pm_q <= PM_PDOWN;                                   // [R8]
               end else if (enter_idle) begin
                  pm_q <= PM_IDLE;                                    // [R7]
               end
            end
            PM_IDLE: begin
               if (periph_irq) begin
                  pm_q <= PM_ACTIVE;                                  // [R7]
               end
            end
            PM_PDOWN: begin
               if (pin_low) begin
                  pm_q <= PM_ACTIVE;                                  // [R8]
               end
            end
            default: begin
               pm_q <= PM_ACTIVE;
            end
         endcase
      end
   end

   assign ck.idle = (pm_q == PM_IDLE);                                // [R6]
   assign ck.pd   = (pm_q == PM_PDOWN);                               // [R8]
   assign ck.slow = slow_q;

   clk_divider #(
      .DIV (SLOW_DIV)
   ) u_clk_divider (
      .pclk    (pclk),
      .presetn (presetn),
      .ck      (ck)
   );

   assign cpu_clk_en    = ck.cpu_en;
   assign periph_clk_en = ck.per_en;
   assign osc_en        = (pm_q != PM_PDOWN);                         // [R8]
   assign power_mode    = pm_q;

   // ************************************************************
   // interrupts
   // ************************************************************
   assign ev[`IRQ_WDT]       = fire;
   assign ev[`IRQ_IDLE_EXIT] = (pm_q == PM_IDLE) && periph_irq && !int_rst;
   assign ev[`IRQ_PD_EXIT]   = (pm_q == PM_PDOWN) && pin_low && !int_rst;

   // a new event beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= `IRQ_RESET;
      end else begin
         stat_q <= (stat_q & ~(wr_stat ? pwdata[2:0] : 3'h0)) | ev;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= `IRQ_RESET;
      end else if (wr_mask) begin
         mask_q <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign irq = irq_q;

   // ************************************************************
   // assertions
   // ************************************************************
   localparam int RST_HOLD = RST_CYC - 1;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   wdt_fire_a: assert property ( // [R1] [R3]
      wd_q == WD_RUN && cnt_q == WDT_LIMIT && !wr_refresh |=> wdt_reset_out && flag_q)
      else $error("watchdog did not fire at limit");
   refresh_clear_a: assert property ( // [R1]
      wr_refresh |=> cnt_q == 16'h0000 && !wdt_reset_out || $past(wd_q) == WD_RST)
      else $error("refresh did not clear the counter");
   reset_length_a: assert property ( // [R3]
      $rose(wdt_reset_out) |-> ##[RST_HOLD:RST_HOLD] wdt_reset_out ##1 !wdt_reset_out)
      else $error("internal reset length wrong");
   no_stop_a: assert property ( // [R2]
      wd_q != WD_OFF |=> wd_q != WD_OFF)
      else $error("watchdog stopped");
   start_sw_a: assert property ( // [R2]
      wd_q == WD_OFF && !(wr_ctrl && pwdata[`CTRL_START]) |=> wd_q == WD_OFF)
      else $error("watchdog started without software");
   wdt_keep_a: assert property ( // [R4]
      wdt_reset_out |=> wd_q != WD_OFF && pm_q == PM_ACTIVE && !slow_q)
      else $error("watchdog reset behaved unlike a reset");
   flag_set_a: assert property ( // [R5]
      $rose(wdt_reset_out) |-> flag_q)
      else $error("watchdog flag not set");
   idle_gate_a: assert property ( // [R6] [R11]
      pm_q == PM_IDLE |-> !cpu_clk_en && osc_en)
      else $error("cpu clock not gated in idle");
   idle_exit_a: assert property ( // [R7]
      pm_q == PM_IDLE && periph_irq |=> pm_q == PM_ACTIVE)
      else $error("idle not left on interrupt");
   pd_exit_a: assert property ( // [R8]
      pm_q == PM_PDOWN |-> (!osc_en && !periph_clk_en) and (pin_low |=> pm_q == PM_ACTIVE))
      else $error("power down wrong");
   pd_hold_a: assert property ( // [R9]
      pm_q == PM_PDOWN && !pin_low |=> $stable(cnt_q) && $stable(slow_q) && $stable(mask_q))
      else $error("state changed in power down");
   slow_div_a: assert property ( // [R10]
      (slow_q && periph_clk_en) ##1 (slow_q && pm_q != PM_PDOWN && !periph_clk_en)[*7]
      |=> slow_q && pm_q != PM_PDOWN |-> periph_clk_en)
      else $error("slow divider period wrong");
   seq_only_a: assert property ( // [R12]
      pm_q == PM_ACTIVE && !int_rst && wr_power_control_register && !idle_arm_q && !pd_arm_q |=> pm_q == PM_ACTIVE)
      else $error("mode entered without arming write");

   idle_seen_c: cover property (pm_q == PM_ACTIVE ##1 pm_q == PM_IDLE);
   pd_seen_c: cover property (pm_q == PM_PDOWN ##1 pm_q == PM_ACTIVE);
   wdt_seen_c: cover property ($rose(wdt_reset_out));
   slow_idle_c: cover property (pm_q == PM_IDLE && slow_q && periph_clk_en);
endmodule // wdpm_top

/* File: tb/watchdog_and_power_modes_tb.sv */
// self-checking bench for the watchdog and power mode controller
// assumes wdpm_top with apb access, sped up by a short watchdog limit
`timescale 1ns/10ps
`include "wdpm_regs.svh"
module watchdog_and_power_modes_tb;
   import wdpm_pkg::*;
   // **********************************************
   // short watchdog so the run stays brief
   // **********************************************
   localparam int LIM  = 16;
   localparam int TICK = 1;
   localparam int RST  = 40;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        periph_irq;
   logic        ext_pin;
   logic        irq;
   logic        wdt_reset_out;
   logic        cpu_clk_en;
   logic        periph_clk_en;
   logic        osc_en;
   pm_type      power_mode;
   int          error_cnt;
   int          check_count;
   int          wd_hi;
   int          n;
   int          ce;
   int          pe;
   logic [31:0] rd;
   logic [31:0] msk;
   logic        err;

   wdpm_top #(.TICK_CYC(TICK), .WDT_LIMIT(16'h0010), .RST_CYC(RST), .SLOW_DIV(8)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .periph_irq(periph_irq), .ext_interrupt0_pin(ext_pin), .irq(irq),
      .wdt_reset_out(wdt_reset_out), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .osc_en(osc_en), .power_mode(power_mode));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // **********************************************
   // compare, bus and timing tasks
   // **********************************************
   task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_bit(input string nm, input logic e, input logic g);
      chk_word(nm, {31'h0, e}, {31'h0, g});
   endtask
   task chk_num(input string nm, input int e, input int g);
      check_count++;
      if (g != e) begin
         error_cnt++;
         $display("ERROR %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   // request held until pready is seen high at an edge
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int t;
      t = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      err = pslverr;
      chk_bit("pready", 1'b1, pready);
      psel <= 1'b0; penable <= 1'b0;
      // one idle edge so the next call never reassigns psel in this time step
      @(posedge pclk);
   endtask
   task count_en(input int k);
      ce = 0;
      pe = 0;
      repeat (k) begin
         @(posedge pclk);
         ce += (cpu_clk_en === 1'b1);
         pe += (periph_clk_en === 1'b1);
      end
   endtask
   function automatic int exp_timeout();
      return LIM * TICK + 1;
   endfunction

   always @(posedge pclk) if (wdt_reset_out === 1'b1) wd_hi <= wd_hi + 1;

   task complete_run;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog on the bench itself: far beyond the few hundred cycles needed
   initial begin
      #3_000_000;
      error_cnt++;
      complete_run;
   end

   // **********************************************
   // main sequence
   // **********************************************
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0000_0000; periph_irq = 1'b0; ext_pin = 1'b1;
      error_cnt = 0; check_count = 0; wd_hi = 0;
      void'($urandom(32'h9e56));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_word("mode", {30'h0, PM_ACTIVE}, {30'h0, power_mode});
      apb(`OFF_STATUS, 1'b0, 32'h0); chk_word("status", 32'h0000_0000, rd);
      apb(8'h40, 1'b0, 32'h0); chk_bit("slverr", 1'b1, err);
      // lone set writes, and a write between, must not enter idle
      apb(`OFF_POWER, 1'b1, 32'h0000_0020);
      apb(`OFF_POWER, 1'b1, 32'h0000_0001);
      apb(`OFF_REFRESH, 1'b1, 32'h0000_0000);
      apb(`OFF_POWER, 1'b1, 32'h0000_0020); cyc(1);
      chk_word("mode", {30'h0, PM_ACTIVE}, {30'h0, power_mode});
      // idle entry and exit by a peripheral interrupt
      apb(`OFF_POWER, 1'b1, 32'h0000_0001);
      apb(`OFF_POWER, 1'b1, 32'h0000_0020); cyc(1);
      chk_word("mode", {30'h0, PM_IDLE}, {30'h0, power_mode});
      count_en(16); chk_num("cpu en", 0, ce); chk_num("per en", 16, pe);
      periph_irq <= 1'b1; cyc(1); periph_irq <= 1'b0; cyc(2);
      chk_word("mode", {30'h0, PM_ACTIVE}, {30'h0, power_mode});
      apb(`OFF_IRQ_STAT, 1'b0, 32'h0); chk_word("irq stat", 32'h0000_0002, rd & 32'h0000_0007);
      // masking and clearing of the level interrupt
      apb(`OFF_IRQ_MASK, 1'b1, 32'h0000_0002); cyc(1); chk_bit("irq", 1'b1, irq);
      apb(`OFF_IRQ_MASK, 1'b1, 32'h0000_0000); cyc(1); chk_bit("irq", 1'b0, irq);
      apb(`OFF_IRQ_MASK, 1'b1, 32'h0000_0002);
      apb(`OFF_IRQ_STAT, 1'b1, 32'h0000_0002); cyc(1); chk_bit("irq", 1'b0, irq);
      msk = $urandom & 32'h0000_0007;
      apb(`OFF_IRQ_MASK, 1'b1, msk);
      apb(`OFF_IRQ_MASK, 1'b0, 32'h0); chk_word("mask", msk, rd);
      // idle with slow down, then slow alone, then full speed
      apb(`OFF_POWER, 1'b1, 32'h0000_0001);
      apb(`OFF_POWER, 1'b1, 32'h0000_0030); cyc(1);
      count_en(16); chk_num("cpu en", 0, ce); chk_num("per en", 2, pe);
      periph_irq <= 1'b1; cyc(1); periph_irq <= 1'b0; cyc(2);
      count_en(16); chk_num("cpu en", 2, ce); chk_num("per en", 2, pe);
      apb(`OFF_POWER, 1'b1, 32'h0000_0000); cyc(1);
      count_en(16); chk_num("cpu en", 16, ce); chk_num("per en", 16, pe);
      // power down keeps registers and leaves on a pin pulse
      apb(`OFF_POWER, 1'b1, 32'h0000_0002);
      apb(`OFF_POWER, 1'b1, 32'h0000_0042); cyc(1);
      chk_word("mode", {30'h0, PM_PDOWN}, {30'h0, power_mode});
      chk_bit("osc", 1'b0, osc_en);
      apb(`OFF_IRQ_MASK, 1'b1, ~msk & 32'h0000_0007);
      ext_pin <= 1'b0; cyc(6); ext_pin <= 1'b1; cyc(2);
      chk_word("mode", {30'h0, PM_ACTIVE}, {30'h0, power_mode});
      chk_bit("osc", 1'b1, osc_en);
      apb(`OFF_IRQ_MASK, 1'b0, 32'h0); chk_word("mask", msk, rd);
      apb(`OFF_IRQ_STAT, 1'b0, 32'h0); chk_word("pd exit", 32'h0000_0004, rd & 32'h0000_0004);
      // watchdog: start, try to stop, refresh at random gaps
      apb(`OFF_CTRL, 1'b1, 32'h0000_0001);
      apb(`OFF_CTRL, 1'b1, 32'h0000_0000);
      apb(`OFF_STATUS, 1'b0, 32'h0); chk_word("running", 32'h0000_0002, rd & 32'h0000_0002);
      repeat (20) begin
         cyc($urandom_range(0, 8));
         apb(`OFF_REFRESH, 1'b1, $urandom);
      end
      chk_num("early reset", 0, wd_hi);
      // let it expire while idle; the internal reset must end idle too
      apb(`OFF_POWER, 1'b1, 32'h0000_0001);
      apb(`OFF_POWER, 1'b1, 32'h0000_0020);
      apb(`OFF_REFRESH, 1'b1, 32'h0000_0000);
      n = 0;
      while (wdt_reset_out !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk_bit("timeout", 1'b1, n >= exp_timeout() - 2 && n <= exp_timeout() + 2);
      n = 0;
      while (wdt_reset_out === 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk_num("reset width", RST, n);
      apb(`OFF_REFRESH, 1'b1, 32'h0000_0000);
      chk_word("mode", {30'h0, PM_ACTIVE}, {30'h0, power_mode});
      apb(`OFF_STATUS, 1'b0, 32'h0); chk_word("status", 32'h0000_0003, rd & 32'h0000_003F);
      apb(`OFF_IRQ_STAT, 1'b0, 32'h0); chk_word("wd stat", 32'h0000_0001, rd & 32'h0000_0001);
      complete_run;
   end
endmodule // watchdog_and_power_modes_tb
